// ### core/pfpm_pkg.sv
// Shared constants and types for the point-of-load fault protection monitor
package pfpm_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;                        // APB byte address width
	localparam int DATA_W = 32;                       // APB data width

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;        // Tracking enable, fault clear
	localparam logic [7:0] REG_THR    = 8'h04;        // Threshold codes
	localparam logic [7:0] REG_LATCH  = 8'h08;        // Latching mode per fault
	localparam logic [7:0] REG_STATUS = 8'h0C;        // Sticky events, cleared on read
	localparam logic [7:0] REG_MASK   = 8'h10;        // Interrupt mask
	localparam logic [7:0] REG_STATE  = 8'h14;        // Live state, read only

	// Field positions
	localparam int CTRL_TRK   = 0;                    // Tracking protection enable
	localparam int CTRL_CLR   = 1;                    // Write one to clear a latched fault
	localparam int THR_OC_LSB = 0;                    // Overcurrent code, 4 bits
	localparam int THR_OV_LSB = 4;                    // Overvoltage code, 2 bits
	localparam int THR_UV_LSB = 6;                    // Undervoltage code, 2 bits
	localparam int THR_PG_BIT = 8;                    // Window lower edge code, 1 bit

	// Fault cause bit order, used in cause, latch mode and status
	localparam int C_OC  = 0;
	localparam int C_OV  = 1;
	localparam int C_UV  = 2;
	localparam int C_OT  = 3;
	localparam int C_TRK = 4;
	localparam int NCAUSE = 5;
	localparam int EV_WRN = 5;                        // Warning rose
	localparam int EV_PG  = 6;                        // Window output changed
	localparam int NEV    = 7;

	// Delay filter index order
	localparam int F_OV  = 0;
	localparam int F_UV  = 1;
	localparam int F_OT  = 2;
	localparam int F_TRK = 3;
	localparam int F_WRN = 4;
	localparam int F_PG  = 5;
	localparam int NFILT = 6;

	// Reset values
	localparam logic [3:0] OC_CODE_RST = 4'hA;        // 180 percent
	localparam logic [1:0] OV_CODE_RST = 2'h2;        // 130 percent
	localparam logic [1:0] UV_CODE_RST = 2'h0;        // 75 percent
	localparam logic       PG_CODE_RST = 1'h0;        // 90 percent
	localparam logic [4:0] LATCH_RST   = 5'h00;       // All non-latching
	localparam logic [6:0] MASK_RST    = 7'h00;       // All masked

	// Threshold arithmetic, percent values
	localparam logic [3:0] OC_MAX   = 4'hA;           // Eleven steps, codes 0..10
	localparam logic [7:0] OC_BASE  = 8'h3C;          // 60 percent
	localparam logic [7:0] OC_STEP  = 8'h0C;          // 12 percent per step
	localparam logic [1:0] OV_MAX   = 2'h2;
	localparam logic [7:0] OV_BASE  = 8'h6E;          // 110 percent
	localparam logic [7:0] OV_STEP  = 8'h0A;          // 10 percent per step
	localparam logic [1:0] UV_MAX   = 2'h2;
	localparam logic [7:0] UV_BASE  = 8'h4B;          // 75 percent
	localparam logic [7:0] UV_STEP  = 8'h05;          // 5 percent per step
	localparam logic [7:0] PG_BASE  = 8'h5A;          // 90 percent
	localparam logic [7:0] PG_STEP  = 8'h05;          // 5 percent per step
	localparam logic [7:0] PG_HI    = 8'h6E;          // 110 percent
	localparam logic [24:0] PCT_SCALE  = 25'h0000064; // Hundred
	localparam logic [24:0] OV_FLOOR_X = 25'h00186A0; // 1000 mV times a hundred
	localparam logic [15:0] TRK_LIM_MV = 16'h00FA;    // 250 mV

	// Temperatures in degrees C
	localparam logic signed [9:0] OT_OFF  = 10'sh082; // 130
	localparam logic signed [9:0] OT_ON   = 10'sh078; // 120
	localparam logic signed [9:0] WRN_ON  = 10'sh078; // 120
	localparam logic signed [9:0] WRN_CLR = 10'sh075; // 120 less 3 of hysteresis

	// Timing
	localparam int CLK_NS    = 25;                    // 40 MHz
	localparam int FILT_NS   = 6000;                  // 6 us
	localparam int FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int RETRY_MS  = 130;                   // 130 ms
	localparam int RETRY_CYC = RETRY_MS * 1000000 / CLK_NS;

	// Protection state
	typedef enum logic [1:0] {ST_RUN, ST_RETRY, ST_OTWAIT, ST_LATCH} pfpm_state_t;
endpackage : pfpm_pkg

// ### core/pfpm_monitor.sv
// Fault protection and output window supervisor with its APB register file
// What this block does
// - Overcurrent trips above 60..180 percent, eleven steps
// - Overvoltage trips above 110/120/130 percent of setpoint
// - Overvoltage trip level never below one volt
// - Undervoltage trips below 75/80/85 percent setpoint
// - Voltage, temperature, tracking faults act after 6 us
// - Per-fault latching, else retry after 130 ms; non-latching overtemperature waits for 120 instead
// - Overtemperature off at 130, restart at 120
// - Tracking off by default, latching or retrying
// - Tracking only while ramping, 250 mV window
// - Warning flag at 120, 3 degree hysteresis
// - Warning flag raised 6 us after crossing
// - Window pin high inside 90/95..110 percent
// - Window pin changes 6 us after crossing
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pfpm_monitor #(
	parameter int RETRY_CYCLES = pfpm_pkg::RETRY_CYC      // Retry wait in clock cycles
) (
	input  wire logic                          clk_in,
	input  wire logic                          rstn_in,
	input  wire logic [pfpm_pkg::ADDR_W-1:0]   paddr_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [pfpm_pkg::DATA_W-1:0]   pwdata_in,
	output logic      [pfpm_pkg::DATA_W-1:0]   prdata_out,
	output logic                               pready_out,
	output logic                               pslverr_out,
	input  wire logic [15:0]                   vout_mv_in,
	input  wire logic [15:0]                   vset_mv_in,
	input  wire logic [15:0]                   vref_mv_in,
	input  wire logic                          ramping_in,
	input  wire logic [7:0]                    iout_pct_in,
	input  wire logic signed [9:0]             temp_c_in,
	input  wire logic                          enable_in,
	output logic                               turn_off_out,
	output logic                               output_in_window_pin_out,
	output logic                               irq_out
);
	import pfpm_pkg::*;

	// Refuse settings the counters cannot serve
	if (RETRY_CYCLES < 2) begin : g_chk_retry
		$error("RETRY_CYCLES must be at least two");
	end
	if (FILT_CYC < 1 || FILT_CYC > 256) begin : g_chk_filt
		$error("Filter delay must fit an eight bit counter");
	end

	localparam logic [7:0]  FILT_LAST = 8'(FILT_CYC - 1);     // Last filter count
	localparam logic [31:0] RETRY_END = 32'(RETRY_CYCLES - 1); // Last retry count

	logic                 trk_en;          // Tracking protection enable
	logic [3:0]           oc_code;         // Overcurrent step
	logic [1:0]           ov_code;         // Overvoltage step
	logic [1:0]           uv_code;         // Undervoltage step
	logic                 pg_code;         // Window lower edge step
	logic [NCAUSE-1:0]    latch_mode;      // One bit per fault, set for latching
	logic [NEV-1:0]       status;          // Sticky events
	logic [NEV-1:0]       mask;            // Interrupt enables
	logic [NCAUSE-1:0]    cause;           // Faults behind the last shutdown
	pfpm_state_t          state;           // Protection state
	pfpm_state_t          next_state;      // Its next value
	logic [31:0]          timer;           // Retry wait counter
	logic                 en_m;            // Enable pin, first stage
	logic                 en_s;            // Enable pin, synchronised
	logic                 en_d;            // Synchronised enable, one cycle late
	logic                 warn_d;          // Warning flag, one cycle late
	logic                 pg_d;            // Window output, one cycle late
	logic [NFILT-1:0]     tgt;             // Level each filter is heading for
	logic                 filt_q [NFILT];  // Filtered levels
	logic [7:0]           cnt [NFILT];     // Filter counters

	// Bus decode
	logic acc, wr, rd, hit, clr_req, en_fall, running, trip_evt;
	logic [NCAUSE-1:0] trip;                          // Present fault levels
	logic [NEV-1:0]    ev;                            // Events this cycle
	assign acc     = psel_in & penable_in;
	assign wr      = acc & pwrite_in;
	assign rd      = acc & ~pwrite_in;
	assign hit     = paddr_in inside {REG_CTRL, REG_THR, REG_LATCH, REG_STATUS,
	                                  REG_MASK, REG_STATE};
	assign pready_out  = 1'b1;                        // Zero wait states
	assign pslverr_out = acc & ~hit;                  // Unmapped address
	assign clr_req = wr && paddr_in == REG_CTRL && pwdata_in[CTRL_CLR];
	assign en_fall = en_d & ~en_s;                    // Enable cycled off

	// Enable pin synchroniser
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_m <= 1'b0;
			en_s <= 1'b0;
			en_d <= 1'b0;
		end else begin
			en_m <= enable_in;
			en_s <= en_m;
			en_d <= en_s;
		end
	end

	// Software written settings
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			trk_en     <= 1'b0;
			oc_code    <= OC_CODE_RST;
			ov_code    <= OV_CODE_RST;
			uv_code    <= UV_CODE_RST;
			pg_code    <= PG_CODE_RST;
			latch_mode <= LATCH_RST;
			mask       <= MASK_RST;
		end else if (wr) begin
			if (paddr_in == REG_CTRL) begin
				trk_en <= pwdata_in[CTRL_TRK];
			end
			// Out of range codes saturate at the top step
			if (paddr_in == REG_THR) begin
				oc_code <= (pwdata_in[THR_OC_LSB +: 4] > OC_MAX) ? OC_MAX
				         : pwdata_in[THR_OC_LSB +: 4];
				ov_code <= (pwdata_in[THR_OV_LSB +: 2] > OV_MAX) ? OV_MAX
				         : pwdata_in[THR_OV_LSB +: 2];
				uv_code <= (pwdata_in[THR_UV_LSB +: 2] > UV_MAX) ? UV_MAX
				         : pwdata_in[THR_UV_LSB +: 2];
				pg_code <= pwdata_in[THR_PG_BIT];
			end
			if (paddr_in == REG_LATCH) begin
				latch_mode <= pwdata_in[NCAUSE-1:0];
			end
			if (paddr_in == REG_MASK) begin
				mask <= pwdata_in[NEV-1:0];
			end
		end
	end

	// Voltage thresholds as percent of setpoint, compared against output times a hundred
	logic [7:0]  oc_pct, ov_pct, uv_pct, pg_pct;
	logic [24:0] vout_x, ov_raw, ov_lim, uv_lim, pg_lo, pg_hi;
	logic [15:0] trk_dev;                             // Distance from ramp reference
	assign oc_pct = 8'(OC_BASE + OC_STEP * oc_code);
	assign ov_pct = 8'(OV_BASE + OV_STEP * ov_code);
	assign uv_pct = 8'(UV_BASE + UV_STEP * uv_code);
	assign pg_pct = 8'(PG_BASE + PG_STEP * pg_code);
	assign vout_x = 25'(vout_mv_in) * PCT_SCALE;
	assign ov_raw = 25'(vset_mv_in) * 25'(ov_pct);
	assign ov_lim = (ov_raw < OV_FLOOR_X) ? OV_FLOOR_X : ov_raw;
	assign uv_lim = 25'(vset_mv_in) * 25'(uv_pct);
	assign pg_lo  = 25'(vset_mv_in) * 25'(pg_pct);
	assign pg_hi  = 25'(vset_mv_in) * 25'(PG_HI);
	assign trk_dev = (vout_mv_in > vref_mv_in) ? 16'(vout_mv_in - vref_mv_in)
	               : 16'(vref_mv_in - vout_mv_in);

	// Raw conditions fed to the delay filters
	always_comb begin
		tgt        = '0;
		tgt[F_OV]  = vout_x > ov_lim;
		// Undervoltage is blanked while the output ramps up from low
		tgt[F_UV]  = ~ramping_in & (vout_x < uv_lim);
		tgt[F_OT]  = temp_c_in >= OT_OFF;
		tgt[F_TRK] = trk_en & ramping_in & (trk_dev > TRK_LIM_MV);
		// Warning sets at 120 and holds until 3 degrees below
		tgt[F_WRN] = filt_q[F_WRN] ? (temp_c_in > WRN_CLR)
		           : (temp_c_in >= WRN_ON);
		tgt[F_PG]  = (vout_x >= pg_lo) & (vout_x <= pg_hi);
	end

	// Delay filters: a level moves only after the new condition held 6 us
	for (genvar i = 0; i < NFILT; i++) begin : g_filt
		always_ff @(posedge clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				cnt[i]    <= 8'h00;
				filt_q[i] <= 1'b0;
			end else if (tgt[i] == filt_q[i]) begin
				cnt[i] <= 8'h00;                          // Agreement restarts timing
			end else if (cnt[i] == FILT_LAST) begin
				filt_q[i] <= tgt[i];
				cnt[i]    <= 8'h00;
			end else begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
	end

	// Fault levels that can shut the output down; the warning is not one of them
	assign trip[C_OC]  = iout_pct_in > oc_pct;
	assign trip[C_OV]  = filt_q[F_OV];
	assign trip[C_UV]  = filt_q[F_UV];
	assign trip[C_OT]  = filt_q[F_OT];
	assign trip[C_TRK] = filt_q[F_TRK];
	assign running  = (state == ST_RUN) & en_s;
	assign trip_evt = running & (|trip);

	// Protection state transitions
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN: begin
				if (trip_evt) begin
					if (|(trip & latch_mode)) begin
						next_state = ST_LATCH;
					end else if (trip[C_OT]) begin
						next_state = ST_OTWAIT;
					end else begin
						next_state = ST_RETRY;
					end
				end
			end
			ST_RETRY: begin
				if (timer == RETRY_END) begin
					next_state = ST_RUN;
				end
			end
			ST_OTWAIT: begin
				if (temp_c_in <= OT_ON) begin
					next_state = ST_RUN;
				end
			end
			ST_LATCH: begin
				next_state = ST_LATCH;
			end
		endcase
		// Clear command or enable cycling releases any off state
		if (state != ST_RUN && (clr_req || en_fall)) begin
			next_state = ST_RUN;
		end
	end

	// State, retry timer and turn-off command
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state        <= ST_RUN;
			timer        <= 32'h0;
			turn_off_out <= 1'b1;
		end else begin
			state        <= next_state;
			timer        <= (state == ST_RETRY && next_state == ST_RETRY)
			              ? timer + 32'h1 : 32'h0;
			turn_off_out <= (next_state != ST_RUN) | ~en_s;
		end
	end

	// Shutdown cause, kept until the next trip
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cause <= '0;
		end else if (trip_evt) begin
			cause <= trip;
		end
	end

	// Window pin straight from its filter
	assign output_in_window_pin_out = filt_q[F_PG];

	// Event edges
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			warn_d <= 1'b0;
			pg_d   <= 1'b0;
		end else begin
			warn_d <= filt_q[F_WRN];
			pg_d   <= filt_q[F_PG];
		end
	end

	always_comb begin
		ev                = '0;
		ev[NCAUSE-1:0]    = trip_evt ? trip : '0;
		ev[EV_WRN]        = filt_q[F_WRN] & ~warn_d;
		ev[EV_PG]         = filt_q[F_PG] ^ pg_d;
	end

	// Sticky status; a read clears only what it reported, new events win
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status <= '0;
		end else begin
			status <= (status & ~((rd && paddr_in == REG_STATUS)
			          ? prdata_out[NEV-1:0] : '0)) | ev;
		end
	end

	// Level interrupt
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status & mask);
		end
	end

	// Read data captured in the setup phase, ready for the access phase
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= '0;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= '0;
			if (paddr_in == REG_CTRL) begin
				prdata_out[CTRL_TRK] <= trk_en;
			end
			if (paddr_in == REG_THR) begin
				prdata_out[8:0] <= {pg_code, uv_code, ov_code, oc_code};
			end
			if (paddr_in == REG_LATCH) begin
				prdata_out[NCAUSE-1:0] <= latch_mode;
			end
			if (paddr_in == REG_STATUS) begin
				prdata_out[NEV-1:0] <= status;
			end
			if (paddr_in == REG_MASK) begin
				prdata_out[NEV-1:0] <= mask;
			end
			if (paddr_in == REG_STATE) begin
				prdata_out[8:0] <= {state == ST_LATCH, turn_off_out, filt_q[F_PG],
				                    filt_q[F_WRN], cause};
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	sequence s_retry_wait;
		state == ST_RETRY && !clr_req && !en_fall;
	endsequence
	sequence s_trip_now;
		running && (|trip);
	endsequence

	a_oc_trip: assert property (running && iout_pct_in > oc_pct |=> turn_off_out)
		else $error("overcurrent did not turn the output off");
	a_ov_level: assert property ($rose(filt_q[F_OV]) |-> $past(vout_x > ov_lim))
		else $error("overvoltage flag without overvoltage");
	a_ov_floor: assert property (ov_lim >= OV_FLOOR_X)
		else $error("overvoltage limit below one volt");
	a_uv_level: assert property ($rose(filt_q[F_UV]) |-> $past(vout_x < uv_lim))
		else $error("undervoltage flag without undervoltage");
	a_ov_delay: assert property ($rose(filt_q[F_OV]) |-> $past(tgt[F_OV], 240))
		else $error("overvoltage acted before 6 us");
	a_retry_hold: assert property (s_retry_wait and timer < RETRY_END |=> state == ST_RETRY)
		else $error("retry ended early");
	a_retry_end: assert property (s_retry_wait and timer == RETRY_END |=> state == ST_RUN)
		else $error("retry did not end on time");
	a_ot_restart: assert property (state == ST_OTWAIT && temp_c_in > OT_ON && !clr_req
		&& !en_fall |=> state == ST_OTWAIT)
		else $error("restarted above 120 degrees");
	a_trk_gate: assert property (!trk_en || !ramping_in |-> !tgt[F_TRK])
		else $error("tracking evaluated outside a ramp");
	a_warn_hold: assert property (filt_q[F_WRN] && temp_c_in > WRN_CLR |=> filt_q[F_WRN])
		else $error("warning dropped inside hysteresis");
	a_warn_delay: assert property ($rose(filt_q[F_WRN]) |-> $past(tgt[F_WRN], 240))
		else $error("warning raised before 6 us");
	a_pg_delay: assert property ($changed(output_in_window_pin_out)
		|-> $past(tgt[F_PG], 240) == output_in_window_pin_out)
		else $error("window pin moved without 6 us of cause");
	a_latch_hold: assert property (s_trip_now ##1 state == ST_LATCH && !clr_req && !en_fall
		|=> state == ST_LATCH && turn_off_out)
		else $error("latched fault released itself");
endmodule : pfpm_monitor

// ### verif/pfpm_manager.sv
// Power manager model: APB master that programs thresholds and reads status
`timescale 1ns/1ps
module pfpm_manager (
	input  wire logic                        clk_in,
	input  wire logic                        pready_in,
	input  wire logic                        pslverr_in,
	input  wire logic [pfpm_pkg::DATA_W-1:0] prdata_in,
	output logic      [pfpm_pkg::ADDR_W-1:0] paddr_out,
	output logic                             psel_out,
	output logic                             penable_out,
	output logic                             pwrite_out,
	output logic      [pfpm_pkg::DATA_W-1:0] pwdata_out
);
	import pfpm_pkg::*;
	// Bus idle from time zero
	initial begin
		paddr_out   = 8'h00;
		psel_out    = 1'b0;
		penable_out = 1'b0;
		pwrite_out  = 1'b0;
		pwdata_out  = 32'h00000000;
	end
	// One whole transfer: setup, access held until ready, then release
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata, output logic err);
		@(posedge clk_in);
		psel_out    <= 1'b1;
		pwrite_out  <= wr;
		paddr_out   <= addr;
		pwdata_out  <= wdata;
		@(posedge clk_in);
		penable_out <= 1'b1;
		@(posedge clk_in);
		// Slave may stretch the access; wait for ready at an edge
		while (pready_in !== 1'b1) @(posedge clk_in);
		rdata = prdata_in;
		err   = pslverr_in;
		psel_out    <= 1'b0;
		penable_out <= 1'b0;
		// Released data no longer shows the last value
		pwdata_out  <= ~wdata;
	endtask : xfer
endmodule : pfpm_manager

// ### verif/pfpm_monitor_bench.sv
// Self-checking bench for the fault protection monitor
`timescale 1ns/1ps
module pfpm_monitor_bench;
	import pfpm_pkg::*;
	localparam int RETRY = 50;              // Shortened retry wait
	logic              clk_in, rstn_in;     // Clock and reset
	logic [7:0]        paddr;               // APB address
	logic              psel, penable, pwrite, pready, pslverr;
	logic [31:0]       pwdata, prdata;      // APB data
	logic [15:0]       vout_mv_in, vset_mv_in, vref_mv_in;
	logic              ramping_in, enable_in;
	logic [7:0]        iout_pct_in;         // Load current
	logic signed [9:0] temp_c_in;           // Controller temperature
	logic              turn_off, pin, irq;  // Design outputs
	logic [31:0]       d;                   // Read data scratch
	logic              e;                   // Error response scratch
	int                errors, checks;      // Tallies
	pfpm_monitor #(.RETRY_CYCLES(RETRY)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.vout_mv_in(vout_mv_in), .vset_mv_in(vset_mv_in), .vref_mv_in(vref_mv_in),
		.ramping_in(ramping_in), .iout_pct_in(iout_pct_in), .temp_c_in(temp_c_in),
		.enable_in(enable_in), .turn_off_out(turn_off), .output_in_window_pin_out(pin),
		.irq_out(irq));
	pfpm_manager mgr (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr),
		.prdata_in(prdata), .paddr_out(paddr), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .pwdata_out(pwdata));
	// Free-running 40 MHz clock
	always #12.5 clk_in = ~clk_in;
	// Compare and tally
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [7:0] a);
		mgr.xfer(1'b0, a, 32'h00000000, d, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] q;
		logic        r;
		mgr.xfer(1'b1, a, v, q, r);
	endtask : wr
	// Let n edges pass, then sample settled outputs
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc
	// Drive the measured quantities at an edge
	task automatic put(input logic [15:0] v, input logic [7:0] i, input logic signed [9:0] t);
		@(posedge clk_in);
		vout_mv_in  <= v;
		iout_pct_in <= i;
		temp_c_in   <= t;
	endtask : put
	// Filtered voltage trip: edge value holds, one past trips at edge 241, then recovers
	task automatic ftrip(input logic [15:0] back, input logic [15:0] ok, input logic [15:0] bad);
		put(ok, 8'h32, 10'sh019);
		cyc(260);
		check(turn_off, 1'b0);
		put(bad, 8'h32, 10'sh019);
		cyc(239);
		check(turn_off, 1'b0);
		cyc(2);
		check(turn_off, 1'b1);
		put(back, 8'h32, 10'sh019);
		cyc(400);
		check(turn_off, 1'b0);
	endtask : ftrip
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Watchdog sized well beyond the expected run
	initial begin
		#(60000 * 25);
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	// Main sequence
	initial begin
		clk_in = 1'b0;
		rstn_in = 1'b0;
		vout_mv_in = 16'h07D0;
		vset_mv_in = 16'h07D0;
		vref_mv_in = 16'h03E8;
		ramping_in = 1'b0;
		iout_pct_in = 8'h32;
		temp_c_in = 10'sh019;
		enable_in = 1'b1;
		errors = 0;
		checks = 0;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		// Reset values and refused access
		rd(REG_CTRL);  check(d, 32'h00000000);
		rd(REG_THR);   check(d, 32'h0000002A);
		rd(REG_LATCH); check(d, 32'h00000000);
		rd(REG_MASK);  check(d, 32'h00000000);
		mgr.xfer(1'b0, 8'h20, 32'h00000000, d, e);
		check({31'h0, e}, 32'h1);
		check(pready, 1'b1);
		check(d, 32'h00000000);
		cyc(260);
		check(turn_off, 1'b0);
		check(pin, 1'b1);
		rd(REG_STATUS); check(d, 32'h00000040);
		$display("test reset done");
		// Overcurrent: every code, edge holds, one above trips, retry releases
		for (int c = 0; c <= 10; c++) begin
			wr(REG_THR, 32'h0000002A & 32'hFFFFFFF0 | c);
			put(16'h07D0, 8'h3C + 8'h0C * c, 10'sh019);
			cyc(5);
			check(turn_off, 1'b0);
			put(16'h07D0, 8'h3D + 8'h0C * c, 10'sh019);
			cyc(2);
			check(turn_off, 1'b1);
			put(16'h07D0, 8'h32, 10'sh019);
			cyc(RETRY - 5);
			check(turn_off, 1'b1);
			cyc(10);
			check(turn_off, 1'b0);
		end
		rd(REG_STATUS); check(d, 32'h00000001);
		rd(REG_STATUS); check(d, 32'h00000000);
		$display("test overcurrent done");
		// Overvoltage and undervoltage, every code
		for (int c = 0; c <= 2; c++) begin
			wr(REG_THR, 32'h0000000A | c << 4 | c << 6);
			ftrip(16'h07D0, 16'h0898 + 16'h00C8 * c, 16'h0899 + 16'h00C8 * c);
			ftrip(16'h07D0, 16'h05DC + 16'h0064 * c, 16'h05DB + 16'h0064 * c);
		end
		// Floor of one volt at a low setpoint, then latching response
		wr(REG_THR, 32'h0000000A);
		@(posedge clk_in);
		vset_mv_in <= 16'h0320;
		ftrip(16'h0320, 16'h03E8, 16'h03E9);
		wr(REG_LATCH, 32'h00000002);
		put(16'h03E9, 8'h32, 10'sh019);
		cyc(245 + RETRY);
		check(turn_off, 1'b1);
		rd(REG_STATE); check({d[8], d[4:0]}, 6'h22);
		put(16'h0320, 8'h32, 10'sh019);
		cyc(260);
		wr(REG_CTRL, 32'h00000002);
		cyc(3);
		check(turn_off, 1'b0);
		wr(REG_LATCH, 32'h00000000);
		@(posedge clk_in);
		vset_mv_in <= 16'h07D0;
		put(16'h07D0, 8'h32, 10'sh019);
		$display("test voltage done");
		// Warning and overtemperature with their hysteresis
		put(16'h07D0, 8'h32, 10'sh079);
		cyc(235);
		rd(REG_STATE); check(d[5], 1'b0);
		cyc(10);
		rd(REG_STATE); check(d[5], 1'b1);
		check(turn_off, 1'b0);
		put(16'h07D0, 8'h32, 10'sh083);
		cyc(239);
		check(turn_off, 1'b0);
		cyc(2);
		check(turn_off, 1'b1);
		put(16'h07D0, 8'h32, 10'sh079);
		cyc(300);
		check(turn_off, 1'b1);
		put(16'h07D0, 8'h32, 10'sh078);
		cyc(300);
		check(turn_off, 1'b0);
		put(16'h07D0, 8'h32, 10'sh076);
		cyc(300);
		rd(REG_STATE); check(d[5], 1'b1);
		put(16'h07D0, 8'h32, 10'sh075);
		cyc(300);
		rd(REG_STATE); check(d[5], 1'b0);
		put(16'h07D0, 8'h32, 10'sh019);
		$display("test temperature done");
		// Tracking: off by default, then both sides of the ramp band
		@(posedge clk_in);
		ramping_in <= 1'b1;
		put(16'h0514, 8'h32, 10'sh019);
		cyc(300);
		check(turn_off, 1'b0);
		wr(REG_CTRL, 32'h00000001);
		ftrip(16'h03E8, 16'h04E2, 16'h04E3);
		ftrip(16'h03E8, 16'h02EE, 16'h02ED);
		wr(REG_CTRL, 32'h00000000);
		@(posedge clk_in);
		ramping_in <= 1'b0;
		put(16'h07D0, 8'h32, 10'sh019);
		cyc(400);
		$display("test tracking done");
		// Window at the 95 percent low edge, both edges inclusive, pin moves at edge 240
		wr(REG_THR, 32'h0000012A);
		put(16'h076C, 8'h32, 10'sh019);
		cyc(300);
		check(pin, 1'b1);
		put(16'h076B, 8'h32, 10'sh019);
		cyc(239);
		check(pin, 1'b1);
		cyc(1);
		check(pin, 1'b0);
		put(16'h0898, 8'h32, 10'sh019);
		cyc(300);
		check(pin, 1'b1);
		put(16'h0899, 8'h32, 10'sh019);
		cyc(239);
		check(pin, 1'b1);
		cyc(1);
		check(pin, 1'b0);
		wr(REG_THR, 32'h0000002A);
		put(16'h07D0, 8'h32, 10'sh019);
		cyc(300);
		check(pin, 1'b1);
		$display("test window done");
		// Enable low keeps the output off, and its fall releases a latched fault
		wr(REG_LATCH, 32'h00000001);
		put(16'h07D0, 8'hB5, 10'sh019);
		put(16'h07D0, 8'h32, 10'sh019);
		cyc(RETRY + 10);
		check(turn_off, 1'b1);
		@(posedge clk_in);
		enable_in <= 1'b0;
		cyc(4);
		check(turn_off, 1'b1);
		@(posedge clk_in);
		enable_in <= 1'b1;
		cyc(5);
		check(turn_off, 1'b0);
		wr(REG_LATCH, 32'h00000000);
		$display("test enable done");
		// Interrupt raised when unmasked, cleared by status read, blocked by mask
		rd(REG_STATUS);
		wr(REG_MASK, 32'h00000001);
		check(irq, 1'b0);
		put(16'h07D0, 8'hB5, 10'sh019);
		cyc(3);
		check(irq, 1'b1);
		put(16'h07D0, 8'h32, 10'sh019);
		rd(REG_STATUS); check(d[0], 1'b1);
		cyc(2);
		check(irq, 1'b0);
		wr(REG_MASK, 32'h00000000);
		cyc(RETRY + 10);
		put(16'h07D0, 8'hB5, 10'sh019);
		cyc(3);
		check(irq, 1'b0);
		put(16'h07D0, 8'h32, 10'sh019);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule : pfpm_monitor_bench
